// >>> rtl/t1m_rx_monitor.sv
// t1m_rx_monitor: receive-side mimic flag, line violation toggles,
// 72-frame alignment bit source and serial status stream.
// assumes framer pins arrive unsynchronised and software uses Avalon-MM.
//
// Notes on behaviour
// - mimic set on second alignment candidate
// - new resynchronization clears mimic flag
// - main toggle flips every 256 violations
// - main toggle at most once per 96ms
// - violations while a toggle is held off are discarded
// - slow 256th violation toggles at once
// - mid and low toggles at 128, 64
// - mid and low toggles ignore rate limit
// - 72-frame pattern: alternating, 000111000111, fields
// - status words sent serially every frame
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module t1m_rx_monitor #(
  parameter int unsigned HOLD_CYCLES = t1m_pkg::HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // framer and line pins
  input wire logic line_violation_i,
  input wire logic align_cand_i,
  input wire logic resync_i,
  input wire logic sync_lock_i,
  input wire logic frame_start_i,
  // outputs
  output logic irq_o,
  output logic control_status_out_stream_o,
  output logic status_mark_o,
  output logic ext_frame_bit_o,
  output logic reframe_req_o
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned NPIN = 5;

  typedef struct packed {
    logic [NPIN-1:0] pin_prev;
    logic searching;
    logic [1:0] cand_cnt;
    logic mimic;
    logic [7:0] viol_cnt;
    logic pend;
    logic [HW-1:0] hold_cnt;
    logic hold_done;
    logic [6:0] free_cnt;
    logic tog_main;
    logic tog_mid;
    logic tog_low;
    logic slc_mode;
    logic [6:0] frame_idx;
    logic frame_bit;
    logic [23:0] field_bits;
    logic reframe;
    logic [t1m_pkg::EV_W-1:0] irq_stat;
    logic [t1m_pkg::EV_W-1:0] irq_en;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } t1m_state_t;

  t1m_state_t q;
  t1m_state_t d;

  logic [NPIN-1:0] pins_s;
  logic [NPIN-1:0] pin_rise;
  logic viol_ev;
  logic cand_ev;
  logic resync_ev;
  logic lock_ev;
  logic frame_ev;
  logic [t1m_pkg::EV_W-1:0] ev;
  logic [15:0] status_words;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  t1m_sync2 #(
    .W(NPIN)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({frame_start_i, sync_lock_i, resync_i, align_cand_i, line_violation_i}),
    .sync_o(pins_s)
  );

  // pins are levels; a rising edge is one event
  // pulses shorter than two clocks may slip past the synchroniser
  assign pin_rise = pins_s & ~q.pin_prev;
  assign viol_ev = pin_rise[0];
  assign cand_ev = pin_rise[1];
  assign resync_ev = pin_rise[2];
  assign lock_ev = pin_rise[3];
  assign frame_ev = pin_rise[4];

  // ----------------------------------------------------------------
  // 72-frame alignment bit
  // ----------------------------------------------------------------
  function automatic logic slc_bit(input logic [6:0] n, input logic [23:0] f);
    logic [5:0] k;
    logic [5:0] m;
    logic b;
    k = n[6:1] - 6'h01;
    m = n[6:1] - 6'h0D;
    if (n[0]) begin
      // odd frames: 1,0,1,0 from frame 1
      b = ~n[1];
    end else if (n <= 7'(t1m_pkg::SEC_LAST)) begin
      b = t1m_pkg::SEC_PATTERN[k[3:0]];
    end else begin
      // even frames 26..72 carry host field bits, frame 26 in bit 0
      b = f[m[4:0]];
    end
    return b;
  endfunction : slc_bit

  // ----------------------------------------------------------------
  // serial status words
  // ----------------------------------------------------------------
  always_comb begin
    status_words = 16'h0000;
    status_words[8 + t1m_pkg::W1_MIMIC] = q.mimic;
    status_words[8 + t1m_pkg::W1_MAIN] = q.tog_main;
    status_words[8 + t1m_pkg::W1_SEARCH] = q.searching;
    status_words[t1m_pkg::W2_MID] = q.tog_mid;
    status_words[t1m_pkg::W2_LOW] = q.tog_low;
  end

  t1m_status_shift #(
    .W(16)
  ) u_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(frame_ev),
    .word_i(status_words),
    .serial_o(control_status_out_stream_o),
    .mark_o(status_mark_o)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    d.pin_prev = pins_s;
    d.reframe = 1'b0;

    if (resync_ev) begin
      d.searching = 1'b1;
      d.cand_cnt = 2'h0;
      d.mimic = 1'b0;
      // park at the last frame so the next frame start is frame 1
      d.frame_idx = 7'(t1m_pkg::SLC_FRAMES);
      ev[t1m_pkg::EV_RESYNC] = 1'b1;
    end

    if (cand_ev && d.searching) begin
      if (d.cand_cnt != 2'h0 && !d.mimic) begin
        d.mimic = 1'b1;
        ev[t1m_pkg::EV_MIMIC] = 1'b1;
      end
      if (d.cand_cnt != 2'h3) begin
        d.cand_cnt = d.cand_cnt + 2'h1;
      end
    end
    if (lock_ev) begin
      d.searching = 1'b0;
    end

    // hold-off timer since last toggle
    // timer starts at reset, so even the first toggle waits for it
    if (!q.hold_done) begin
      if (q.hold_cnt == HW'(HOLD_CYCLES - 1)) begin
        d.hold_done = 1'b1;
      end else begin
        d.hold_cnt = q.hold_cnt + HW'(1);
      end
    end

    // held toggle released at end of hold-off
    if (q.pend && q.hold_done) begin
      d.pend = 1'b0;
      d.viol_cnt = 8'h00;
      d.tog_main = ~q.tog_main;
      d.hold_cnt = '0;
      d.hold_done = 1'b0;
      ev[t1m_pkg::EV_MAIN] = 1'b1;
    end

    if (viol_ev) begin
      d.free_cnt = q.free_cnt + 7'h01;
      if (q.free_cnt[5:0] == 6'(t1m_pkg::VIOL_LOW - 1)) begin
        d.tog_low = ~q.tog_low;
        ev[t1m_pkg::EV_LOW] = 1'b1;
      end
      if (q.free_cnt == 7'(t1m_pkg::VIOL_MID - 1)) begin
        d.tog_mid = ~q.tog_mid;
        ev[t1m_pkg::EV_MID] = 1'b1;
      end
      // dropped while a toggle is held off
      if (!d.pend) begin
        if (d.viol_cnt == 8'(t1m_pkg::VIOL_MAIN - 1)) begin
          if (q.hold_done) begin
            d.tog_main = ~q.tog_main;
            d.viol_cnt = 8'h00;
            d.hold_cnt = '0;
            d.hold_done = 1'b0;
            ev[t1m_pkg::EV_MAIN] = 1'b1;
          end else begin
            d.pend = 1'b1;
          end
        end else begin
          d.viol_cnt = d.viol_cnt + 8'h01;
        end
      end
    end

    if (frame_ev) begin
      if (d.frame_idx >= 7'(t1m_pkg::SLC_FRAMES)) begin
        d.frame_idx = 7'h01;
      end else begin
        d.frame_idx = d.frame_idx + 7'h01;
      end
      d.frame_bit = q.slc_mode & slc_bit(d.frame_idx, q.field_bits);
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait state: answer prepared, then waitrequest drops for one cycle
    if ((avs_read_i || avs_write_i) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata = 32'h00000000;
      if (avs_read_i) begin
        unique case (avs_address_i)
          t1m_pkg::REG_CTRL: begin
            d.rdata[t1m_pkg::CTRL_SLC] = q.slc_mode;
          end
          t1m_pkg::REG_STATUS: begin
            d.rdata[t1m_pkg::ST_MIMIC] = q.mimic;
            d.rdata[t1m_pkg::ST_MAIN] = q.tog_main;
            d.rdata[t1m_pkg::ST_MID] = q.tog_mid;
            d.rdata[t1m_pkg::ST_LOW] = q.tog_low;
            d.rdata[t1m_pkg::ST_SEARCH] = q.searching;
            d.rdata[t1m_pkg::ST_PEND] = q.pend;
            d.rdata[t1m_pkg::ST_FRAME_LSB +: 7] = q.frame_idx;
          end
          t1m_pkg::REG_VCOUNT: begin
            d.rdata[7:0] = q.viol_cnt;
          end
          t1m_pkg::REG_FIELD: begin
            d.rdata[23:0] = q.field_bits;
          end
          t1m_pkg::REG_IRQ_STAT: begin
            d.rdata[t1m_pkg::EV_W-1:0] = q.irq_stat;
          end
          t1m_pkg::REG_IRQ_EN: begin
            d.rdata[t1m_pkg::EV_W-1:0] = q.irq_en;
          end
          default: begin
            d.rdata = 32'h00000000;
          end
        endcase
      end
    end else begin
      d.waitreq = 1'b1;
    end

    // interrupt status: a new event beats a clear in the same cycle
    d.irq_stat = q.irq_stat;
    if (avs_write_i && !q.waitreq) begin
      unique case (avs_address_i)
        t1m_pkg::REG_CTRL: begin
          d.slc_mode = avs_writedata_i[t1m_pkg::CTRL_SLC];
          d.reframe = avs_writedata_i[t1m_pkg::CTRL_REFRAME];
        end
        t1m_pkg::REG_FIELD: begin
          d.field_bits = avs_writedata_i[23:0];
        end
        t1m_pkg::REG_IRQ_EN: begin
          d.irq_en = avs_writedata_i[t1m_pkg::EV_W-1:0];
        end
        t1m_pkg::REG_IRQ_CLR: begin
          d.irq_stat = q.irq_stat & ~avs_writedata_i[t1m_pkg::EV_W-1:0];
        end
        default: begin
          d.irq_stat = q.irq_stat;
        end
      endcase
    end
    d.irq_stat = d.irq_stat | ev;
    d.irq = |(d.irq_stat & d.irq_en);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // counters, timer, mimic, toggles to zero
      q <= '0;
      q.waitreq <= 1'b1;
      q.frame_idx <= 7'(t1m_pkg::SLC_FRAMES);
      q.irq_en <= t1m_pkg::IRQ_EN_RST;
      q.field_bits <= t1m_pkg::FIELD_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.waitreq;
  assign irq_o = q.irq;
  assign ext_frame_bit_o = q.frame_bit;
  assign reframe_req_o = q.reframe;

endmodule : t1m_rx_monitor

// >>> rtl/t1m_pkg.sv
// t1m_pkg: shared constants of the receive violation and mimic monitor.
// assumes a 100 MHz system clock and a word-addressed Avalon-MM slave port.
package t1m_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 100_000;
  localparam int unsigned HOLD_MS = 96;
  // rate limit of the main violation toggle, in clock cycles
  localparam int unsigned HOLD_CYCLES = HOLD_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // violation counts
  // ----------------------------------------------------------------
  localparam int unsigned VIOL_MAIN = 256;
  localparam int unsigned VIOL_MID = 128;
  localparam int unsigned VIOL_LOW = 64;

  // ----------------------------------------------------------------
  // 72-frame loop-carrier format
  // ----------------------------------------------------------------
  localparam int unsigned SLC_FRAMES = 72;
  localparam int unsigned SEC_LAST = 24;
  // secondary bits of even frames 2..24, frame 2 in bit 0
  localparam logic [11:0] SEC_PATTERN = 12'hE38;

  // ----------------------------------------------------------------
  // register word offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_VCOUNT = 4'h2;
  localparam logic [3:0] REG_FIELD = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_EN = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR = 4'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SLC = 0;
  localparam int unsigned CTRL_REFRAME = 1;
  localparam int unsigned ST_MIMIC = 0;
  localparam int unsigned ST_MAIN = 1;
  localparam int unsigned ST_MID = 2;
  localparam int unsigned ST_LOW = 3;
  localparam int unsigned ST_SEARCH = 4;
  localparam int unsigned ST_PEND = 5;
  localparam int unsigned ST_FRAME_LSB = 8;
  localparam int unsigned EV_MIMIC = 0;
  localparam int unsigned EV_MAIN = 1;
  localparam int unsigned EV_MID = 2;
  localparam int unsigned EV_LOW = 3;
  localparam int unsigned EV_RESYNC = 4;
  localparam int unsigned EV_W = 5;
  // serial master status word bit positions (word 1 leads)
  localparam int unsigned W1_MIMIC = 6;
  localparam int unsigned W1_MAIN = 2;
  localparam int unsigned W1_SEARCH = 0;
  localparam int unsigned W2_MID = 4;
  localparam int unsigned W2_LOW = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [EV_W-1:0] IRQ_EN_RST = 5'h00;
  localparam logic [23:0] FIELD_RST = 24'h000000;

endpackage : t1m_pkg

// >>> rtl/t1m_sync2.sv
// t1m_sync2: two flip-flop synchroniser for a group of pin levels.
// assumes each bit is an independent level; no bus coherence.
`timescale 1ns/10ps
module t1m_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } t1m_sync_t;

  t1m_sync_t q;
  t1m_sync_t d;

  always_comb begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;

endmodule : t1m_sync2

// >>> rtl/t1m_status_shift.sv
// t1m_status_shift: serialises the master status words, msb first.
// assumes load comes once per frame, at least W cycles apart.
`timescale 1ns/10ps
module t1m_status_shift #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // parallel side
  input wire logic load_i,
  input wire logic [W-1:0] word_i,
  // serial side
  output logic serial_o,
  output logic mark_o
);

  typedef struct packed {
    logic [W-1:0] sh;
    logic ser;
    logic mark;
  } t1m_shift_t;

  t1m_shift_t q;
  t1m_shift_t d;

  always_comb begin
    d = q;
    d.mark = 1'b0;
    if (load_i) begin
      d.ser = word_i[W-1];
      d.sh = {word_i[W-2:0], 1'b0};
      d.mark = 1'b1;
    end else begin
      d.ser = q.sh[W-1];
      d.sh = {q.sh[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign serial_o = q.ser;
  assign mark_o = q.mark;

endmodule : t1m_status_shift

// >>> test/t1m_sva.sv
// t1m_sva: port-level assertions on the receive monitor.
// assumes one clock domain and an active-high synchronous reset.
`timescale 1ns/10ps
module t1m_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // pins and outputs
  input wire logic frame_start_i,
  input wire logic irq_o,
  input wire logic control_status_out_stream_o,
  input wire logic status_mark_o,
  input wire logic ext_frame_bit_o,
  input wire logic reframe_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_done;
    (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  endsequence
  property p_answer;
    s_take |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_single;
    s_done |=> avs_waitrequest_o;
  endproperty
  a_single: assert property (p_single) else $error("answer held too long");
  property p_unmap;
    avs_read_i && !avs_waitrequest_o && avs_address_i >= t1m_pkg::REG_IRQ_CLR
      |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("write-only or unmapped read not 0");
  property p_rst;
    disable iff (1'b0) rst_i |=> avs_waitrequest_o && !irq_o && !status_mark_o
      && !ext_frame_bit_o && !reframe_req_o && !control_status_out_stream_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_mark;
    $rose(frame_start_i) |-> ##[2:4] status_mark_o;
  endproperty
  a_mark: assert property (p_mark) else $error("status word not started");
  property p_mark_gap;
    status_mark_o |=> (!status_mark_o) [*8];
  endproperty
  a_mark_gap: assert property (p_mark_gap) else $error("status word cut short");
  property p_reframe;
    avs_write_i && !avs_waitrequest_o && avs_address_i == t1m_pkg::REG_CTRL
      && avs_writedata_i[1] |-> ##[0:2] reframe_req_o;
  endproperty
  a_reframe: assert property (p_reframe) else $error("reframe not issued");
  property p_pulse;
    reframe_req_o |=> !reframe_req_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reframe longer than a cycle");
endmodule : t1m_sva

bind t1m_rx_monitor t1m_sva t1m_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .frame_start_i(frame_start_i), .irq_o(irq_o),
  .control_status_out_stream_o(control_status_out_stream_o),
  .status_mark_o(status_mark_o), .ext_frame_bit_o(ext_frame_bit_o),
  .reframe_req_o(reframe_req_o)
);

// >>> test/t1m_line_model.sv
// t1m_line_model: received line pins and a host decoding the status stream.
// assumes pin events need two clocks high and two low.
`timescale 1ns/10ps
module t1m_line_model (
  // clock
  input wire logic clk_i,
  // status stream
  input wire logic stream_i,
  input wire logic mark_i,
  // pins: violation, candidate, resync, lock, frame start
  output logic [4:0] pins_o,
  output logic [15:0] word_o
);
  logic [15:0] sh_q;
  int n_q = 16;
  initial pins_o = 5'h00;
  initial word_o = 16'h0000;
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pins_o[k] <= 1'b1;
      repeat (2) @(posedge clk_i);
      pins_o[k] <= 1'b0;
      @(posedge clk_i);
    end
  endtask : pulse
  always @(posedge clk_i) begin
    if (mark_i) begin
      sh_q <= {15'h0000, stream_i};
      n_q <= 1;
    end else if (n_q < 16) begin
      sh_q <= {sh_q[14:0], stream_i};
      n_q <= n_q + 1;
      if (n_q == 15) word_o <= {sh_q[14:0], stream_i};
    end
  end
endmodule : t1m_line_model

// >>> test/t1m_rx_monitor_bench.sv
// t1m_rx_monitor_bench: self-checking bench of the receive monitor.
// assumes the line model drives the pins and decodes the status stream.
`timescale 1ns/10ps
module t1m_rx_monitor_bench;
  logic clk_i, rst_i, avs_read_i, avs_write_i, irq_o, stream, mark, ext_bit, wait_o, exp;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, rdata, q;
  logic refr;
  logic [4:0] pins;
  logic [15:0] word;
  logic [23:0] field = 24'hA5C3F0;
  int mismatches = 0;
  int samples_checked = 0;
  int ticks = 0;

  // short hold-off so the rate limit shows within the run
  t1m_rx_monitor #(.HOLD_CYCLES(2000)) t1m_rx_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .line_violation_i(pins[0]), .align_cand_i(pins[1]),
    .resync_i(pins[2]), .sync_lock_i(pins[3]), .frame_start_i(pins[4]), .irq_o(irq_o),
    .control_status_out_stream_o(stream), .status_mark_o(mark), .ext_frame_bit_o(ext_bit),
    .reframe_req_o(refr));
  t1m_line_model t1m_line_model_inst (
    .clk_i(clk_i), .stream_i(stream), .mark_i(mark), .pins_o(pins), .word_o(word));

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    q = rdata;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(q & m, want);
  endtask : rd
  task automatic pin(input int k, input int n);
    t1m_line_model_inst.pulse(k, n);
  endtask : pin

  task automatic s_reset;
    rd(t1m_pkg::REG_STATUS, 32'h2F, 32'h0);
    rd(t1m_pkg::REG_VCOUNT, 32'hFF, 32'h0);
    rd(t1m_pkg::REG_IRQ_EN, 32'h1F, 32'h0);
    rd(t1m_pkg::REG_FIELD, 32'hFFFFFFFF, 32'h0);
    rd(4'hF, 32'hFFFFFFFF, 32'h0);
  endtask : s_reset
  task automatic s_mimic;
    bus(1'b1, t1m_pkg::REG_IRQ_EN, 32'h1);
    pin(2, 1);
    pin(1, 2);
    pin(3, 1);
    rd(t1m_pkg::REG_STATUS, 32'h1, 32'h1);
    check(irq_o, 1'b1);
    pin(4, 1);
    repeat (20) @(posedge clk_i);
    check(ext_bit, 1'b0);
    check(word[14], 1'b1);
    check(word[8], 1'b0);
    bus(1'b1, t1m_pkg::REG_IRQ_CLR, 32'h1F);
    pin(2, 1);
    pin(1, 1);
    pin(3, 1);
    check(irq_o, 1'b0);
    rd(t1m_pkg::REG_IRQ_STAT, 32'h11, 32'h10);
    rd(t1m_pkg::REG_STATUS, 32'h1, 32'h0);
  endtask : s_mimic
  task automatic s_viol;
    pin(0, 256);
    rd(t1m_pkg::REG_STATUS, 32'h2E, 32'h20);
    pin(0, 64);
    rd(t1m_pkg::REG_STATUS, 32'h2E, 32'h28);
    rd(t1m_pkg::REG_VCOUNT, 32'hFF, 32'hFF);
    do bus(1'b0, t1m_pkg::REG_STATUS, 32'h0); while (q[1] !== 1'b1);
    check(q & 32'h2E, 32'h0A);
    rd(t1m_pkg::REG_VCOUNT, 32'hFF, 32'h0);
    repeat (1200) @(posedge clk_i);
    pin(0, 255);
    rd(t1m_pkg::REG_STATUS, 32'h2, 32'h2);
    pin(0, 1);
    rd(t1m_pkg::REG_STATUS, 32'h2E, 32'h8);
  endtask : s_viol
  task automatic s_frames;
    bus(1'b1, t1m_pkg::REG_FIELD, {8'h00, field});
    bus(1'b1, t1m_pkg::REG_CTRL, 32'h1);
    for (int n = 1; n <= 72; n++) begin
      pin(4, 1);
      repeat (16) @(posedge clk_i);
      if (n % 2) exp = (n % 4 == 1);
      else if (n <= 24) exp = t1m_pkg::SEC_PATTERN[(n - 2) / 2];
      else exp = field[(n - 26) / 2];
      check(ext_bit, exp);
    end
    repeat (4) @(posedge clk_i);
    check(word[3], 1'b1);
    check(word[4], 1'b0);
    check(word[10], 1'b0);
    rd(t1m_pkg::REG_STATUS, 32'h7F00, 32'h4800);
    bus(1'b1, t1m_pkg::REG_CTRL, 32'h3);
    @(posedge clk_i);
    check(refr, 1'b1);
    @(posedge clk_i);
    check(refr, 1'b0);
    rd(t1m_pkg::REG_CTRL, 32'h3, 32'h1);
  endtask : s_frames

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, well above the expected run
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset;
    s_mimic;
    s_viol;
    s_frames;
    close_out;
  end
endmodule : t1m_rx_monitor_bench
